// File: spm_pkg.sv
// spm_pkg: register map, field layouts, frame states and parity helpers
// assumes one 125 MHz system clock and 32-bit avalon-mm register access
package spm_pkg;
    localparam logic [4:0] SPM_OFS_STAT = 5'h00;
    localparam logic [4:0] SPM_OFS_DATA = 5'h04;
    localparam logic [4:0] SPM_OFS_DIV = 5'h08;
    localparam logic [4:0] SPM_OFS_CTRL = 5'h0C;
    localparam logic [4:0] SPM_OFS_ADDR = 5'h10;
    localparam logic [31:0] SPM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SPM_STAT_RST = 32'h0000_00C0;
    localparam logic [15:0] SPM_DIV_RST = 16'h0000;
    localparam logic [3:0] SPM_ADDR_RST = 4'h0;
    // whole frame in bit times (start, data, one stop), then index of the last data bit
    localparam logic [3:0] SPM_BITS8 = 4'hA;
    localparam logic [3:0] SPM_BITS9 = 4'hB;
    localparam logic [3:0] SPM_LAST8 = 4'h7;
    localparam logic [3:0] SPM_LAST9 = 4'h8;

    typedef struct packed {
        logic [17:0] rsv;
        logic unit_on;
        logic word9;
        logic wake_addr;
        logic parity_on;
        logic parity_odd_sel;
        logic parity_err_irq_en;
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic idle_irq_en;
        logic tx_on;
        logic rx_on;
        logic rx_mute;
        logic rsv0;
    } spm_ctrl_t;

    typedef struct packed {
        logic [23:0] rsv;
        logic tx_empty_flag;
        logic tx_done_flag;
        logic rx_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic [1:0] rsv1;
        logic parity_err_flag;
    } spm_stat_t;

    typedef enum logic [1:0] {
        SPM_IDLE = 2'b00,
        SPM_START = 2'b01,
        SPM_DATA = 2'b11,
        SPM_STOP = 2'b10
    } spm_st_t;

    function automatic logic spm_msb(input logic [8:0] d, input logic nine);
        spm_msb = nine ? d[8] : d[7];
    endfunction : spm_msb

    // parity over the data bits below the top one
    function automatic logic spm_par(input logic [8:0] d, input logic nine,
                                     input logic odd);
        spm_par = (^(d & (nine ? 9'h0FF : 9'h07F))) ^ odd;
    endfunction : spm_par
endpackage : spm_pkg

// File: spm_tx.sv
// spm_tx: frame serialiser, lsb first, one stop bit
// assumes control inputs come from registers on the same clock
`timescale 1ns/1ps
module spm_tx import spm_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic unit_on_i,
    input wire logic tx_on_i,
    input wire logic word9_i,
    input wire logic parity_on_i,
    input wire logic parity_odd_i,
    input wire logic [15:0] div_i,
    input wire logic load_valid_i,
    input wire logic [8:0] load_data_i,
    output logic take_o,
    output logic done_o,
    output logic txd_o
);
    spm_st_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [8:0] sh_r, sh_nxt;
    logic txd_r, txd_nxt;
    logic done_r, done_nxt;
    logic tick;
    logic [8:0] word;

    // divisor 0 and 1 both give one clock per bit
    assign tick = ({1'b0, cnt_r} + 17'h00001) >= {1'b0, div_i};
    assign take_o = (st_r == SPM_IDLE) && unit_on_i && tx_on_i && load_valid_i;
    assign done_o = done_r;
    assign txd_o = txd_r;

    always_comb begin
        word = word9_i ? load_data_i : {1'b0, load_data_i[7:0]};
        if (parity_on_i && word9_i) begin
            word[8] = spm_par(load_data_i, 1'b1, parity_odd_i);
        end else if (parity_on_i) begin
            word[7] = spm_par(load_data_i, 1'b0, parity_odd_i);
        end
        st_nxt = st_r;
        cnt_nxt = tick ? 16'h0000 : cnt_r + 16'h0001;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        txd_nxt = txd_r;
        done_nxt = 1'b0;
        case (st_r)
            SPM_IDLE: begin
                cnt_nxt = 16'h0000;
                txd_nxt = 1'b1;
                if (take_o) begin
                    sh_nxt = word;
                    bit_nxt = word9_i ? SPM_LAST9 : SPM_LAST8;
                    txd_nxt = 1'b0;
                    st_nxt = SPM_START;
                end
            end
            SPM_START: begin
                if (tick) begin
                    txd_nxt = sh_r[0];
                    sh_nxt = sh_r >> 1;
                    st_nxt = SPM_DATA;
                end
            end
            SPM_DATA: begin
                if (tick && bit_r == 4'h0) begin
                    txd_nxt = 1'b1;
                    st_nxt = SPM_STOP;
                end else if (tick) begin
                    txd_nxt = sh_r[0];
                    sh_nxt = sh_r >> 1;
                    bit_nxt = bit_r - 4'h1;
                end
            end
            SPM_STOP: begin
                if (tick) begin
                    done_nxt = 1'b1;
                    st_nxt = SPM_IDLE;
                end
            end
            default: begin
                st_nxt = SPM_IDLE;
            end
        endcase
        // unit off drops the frame at once and parks the line high
        if (!unit_on_i) begin
            st_nxt = SPM_IDLE;
            cnt_nxt = 16'h0000;
            txd_nxt = 1'b1;
            done_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st_r <= SPM_IDLE;
            cnt_r <= 16'h0000;
            bit_r <= 4'h0;
            sh_r <= 9'h000;
            txd_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            txd_r <= txd_nxt;
            done_r <= done_nxt;
        end
    end
endmodule : spm_tx

// File: spm_serial_ctrl.sv
// spm_serial_ctrl: serial transceiver with its main control word
// assumes an avalon-mm master on clk_sys_i and an async line on rxd_i
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module spm_serial_ctrl import spm_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic irq_o
);
    spm_ctrl_t ctrl_r, ctrl_nxt;
    spm_stat_t stat_r, stat_nxt;
    logic [15:0] div_r, div_nxt;
    logic [3:0] addr_r, addr_nxt;
    logic [8:0] tdr_r, tdr_nxt;
    logic tdr_full_r, tdr_full_nxt;
    logic [8:0] rdr_r, rdr_nxt;
    logic stat_rd_r, stat_rd_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic acc, wr_en, rd_en, wr_ctrl;
    logic tx_take, tx_done;

    // receiver state
    logic rxm_r, rxm_nxt;
    logic rxs_r, rxs_nxt;
    spm_st_t rst_r, rst_nxt;
    logic [15:0] rcnt_r, rcnt_nxt;
    logic [3:0] rbit_r, rbit_nxt;
    logic [8:0] rsh_r, rsh_nxt;
    logic [3:0] icnt_r, icnt_nxt;
    logic iarm_r, iarm_nxt;
    logic rx_run, rtick, frame_end;
    logic [8:0] fdata;
    logic perr, is_addr, addr_hit;
    logic rx_accept, idle_evt, mute_set, mute_clr;

    // one wait cycle, answer on the second edge
    assign acc = (avs_read_i | avs_write_i) & ~wait_r;
    assign wr_en = avs_write_i & ~wait_r;
    assign rd_en = avs_read_i & ~wait_r;
    assign wr_ctrl = wr_en && avs_address_i == SPM_OFS_CTRL;
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign irq_o = irq_r;

    spm_tx u_tx (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .unit_on_i(ctrl_r.unit_on),
        .tx_on_i(ctrl_r.tx_on),
        .word9_i(ctrl_r.word9),
        .parity_on_i(ctrl_r.parity_on),
        .parity_odd_i(ctrl_r.parity_odd_sel),
        .div_i(div_r),
        .load_valid_i(tdr_full_r),
        .load_data_i(tdr_r),
        .take_o(tx_take),
        .done_o(tx_done),
        .txd_o(txd_o)
    );

    always_comb begin
        ctrl_nxt = ctrl_r;
        stat_nxt = stat_r;
        div_nxt = div_r;
        addr_nxt = addr_r;
        tdr_nxt = tdr_r;
        tdr_full_nxt = tdr_full_r;
        rdr_nxt = rdr_r;
        stat_rd_nxt = stat_rd_r;
        wait_nxt = !((avs_read_i | avs_write_i) && wait_r);
        rdata_nxt = rdata_r;
        if (avs_read_i && wait_r) begin
            case (avs_address_i)
                SPM_OFS_STAT: rdata_nxt = stat_r;
                SPM_OFS_DATA: rdata_nxt = {23'h000000, rdr_r};
                SPM_OFS_DIV: rdata_nxt = {16'h0000, div_r};
                SPM_OFS_CTRL: rdata_nxt = ctrl_r;
                SPM_OFS_ADDR: rdata_nxt = {28'h0000000, addr_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        if (acc) begin
            stat_rd_nxt = rd_en && avs_address_i == SPM_OFS_STAT;
        end
        if (wr_en) begin
            case (avs_address_i)
                SPM_OFS_CTRL: begin
                    ctrl_nxt = spm_ctrl_t'(avs_writedata_i);
                    ctrl_nxt.rsv = 18'h00000;
                    ctrl_nxt.rsv0 = 1'b0;
                    // mute is locked in address wake mode while a received frame waits
                    if (ctrl_r.wake_addr && stat_r.rx_full_flag) begin
                        ctrl_nxt.rx_mute = ctrl_r.rx_mute;
                    end
                end
                SPM_OFS_DATA: begin
                    tdr_nxt = avs_writedata_i[8:0];
                    tdr_full_nxt = 1'b1;
                    stat_nxt.tx_empty_flag = 1'b0;
                    stat_nxt.tx_done_flag = 1'b0;
                end
                SPM_OFS_DIV: div_nxt = avs_writedata_i[15:0];
                SPM_OFS_ADDR: addr_nxt = avs_writedata_i[3:0];
                default: begin
                end
            endcase
        end
        if (rd_en && avs_address_i == SPM_OFS_DATA) begin
            stat_nxt.rx_full_flag = 1'b0;
            if (stat_rd_r) begin
                stat_nxt.parity_err_flag = 1'b0;
                stat_nxt.overrun_flag = 1'b0;
                stat_nxt.idle_flag = 1'b0;
            end
        end
        // hardware events last so they win over a register access in the same cycle
        if (tx_take) begin
            tdr_full_nxt = 1'b0;
            stat_nxt.tx_empty_flag = 1'b1;
        end
        if (tx_done && !tdr_full_r) begin
            stat_nxt.tx_done_flag = 1'b1;
        end
        if (rx_accept && stat_r.rx_full_flag) begin
            stat_nxt.overrun_flag = 1'b1;
        end else if (rx_accept) begin
            rdr_nxt = fdata;
            stat_nxt.rx_full_flag = 1'b1;
            stat_nxt.parity_err_flag = stat_nxt.parity_err_flag | perr;
        end
        if (idle_evt && !ctrl_r.rx_mute) begin
            stat_nxt.idle_flag = 1'b1;
        end
        if (mute_set) begin
            ctrl_nxt.rx_mute = 1'b1;
        end else if (mute_clr) begin
            ctrl_nxt.rx_mute = 1'b0;
        end
        irq_nxt = (stat_r.parity_err_flag & ctrl_r.parity_err_irq_en)
                | (stat_r.tx_empty_flag & ctrl_r.tx_empty_irq_en)
                | (stat_r.tx_done_flag & ctrl_r.tx_done_irq_en)
                | ((stat_r.rx_full_flag | stat_r.overrun_flag)
                   & ctrl_r.rx_full_irq_en)
                | (stat_r.idle_flag & ctrl_r.idle_irq_en);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl_r <= spm_ctrl_t'(SPM_CTRL_RST);
            stat_r <= spm_stat_t'(SPM_STAT_RST);
            div_r <= SPM_DIV_RST;
            addr_r <= SPM_ADDR_RST;
            tdr_r <= 9'h000;
            tdr_full_r <= 1'b0;
            rdr_r <= 9'h000;
            stat_rd_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            div_r <= div_nxt;
            addr_r <= addr_nxt;
            tdr_r <= tdr_nxt;
            tdr_full_r <= tdr_full_nxt;
            rdr_r <= rdr_nxt;
            stat_rd_r <= stat_rd_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // receiver: samples mid-bit, half a bit after the falling start edge
    assign rx_run = ctrl_r.unit_on & ctrl_r.rx_on;
    assign fdata = ctrl_r.word9 ? rsh_r : {1'b0, rsh_r[8:1]};
    assign perr = ctrl_r.parity_on
        && spm_par(fdata, ctrl_r.word9, ctrl_r.parity_odd_sel)
           != spm_msb(fdata, ctrl_r.word9);
    assign is_addr = spm_msb(fdata, ctrl_r.word9);
    assign addr_hit = is_addr && fdata[3:0] == addr_r;

    always_comb begin
        rxm_nxt = rxd_i;
        rxs_nxt = rxm_r;
        rst_nxt = rst_r;
        rbit_nxt = rbit_r;
        rsh_nxt = rsh_r;
        icnt_nxt = icnt_r;
        iarm_nxt = iarm_r;
        idle_evt = 1'b0;
        frame_end = 1'b0;
        rtick = ({1'b0, rcnt_r} + 17'h00001)
              >= {1'b0, (rst_r == SPM_START) ? (div_r >> 1) : div_r};
        rcnt_nxt = rtick ? 16'h0000 : rcnt_r + 16'h0001;
        case (rst_r)
            SPM_IDLE: begin
                if (!rxs_r) begin
                    rcnt_nxt = 16'h0000;
                    icnt_nxt = 4'h0;
                    rst_nxt = SPM_START;
                end else if (rtick && iarm_r) begin
                    icnt_nxt = icnt_r + 4'h1;
                    if (icnt_nxt == (ctrl_r.word9 ? SPM_BITS9 : SPM_BITS8)) begin
                        idle_evt = 1'b1;
                        iarm_nxt = 1'b0;
                    end
                end
            end
            SPM_START: begin
                if (rtick) begin
                    rst_nxt = rxs_r ? SPM_IDLE : SPM_DATA;
                    rbit_nxt = ctrl_r.word9 ? SPM_LAST9 : SPM_LAST8;
                end
            end
            SPM_DATA: begin
                if (rtick) begin
                    rsh_nxt = {rxs_r, rsh_r[8:1]};
                    rbit_nxt = rbit_r - 4'h1;
                    if (rbit_r == 4'h0) begin
                        rst_nxt = SPM_STOP;
                    end
                end
            end
            SPM_STOP: begin
                if (rtick) begin
                    frame_end = 1'b1;
                    iarm_nxt = 1'b1;
                    icnt_nxt = 4'h0;
                    rst_nxt = SPM_IDLE;
                end
            end
            default: begin
                rst_nxt = SPM_IDLE;
            end
        endcase
        // receiver off: drop the frame and forget the idle history
        if (!rx_run) begin
            rst_nxt = SPM_IDLE;
            rcnt_nxt = 16'h0000;
            iarm_nxt = 1'b0;
            icnt_nxt = 4'h0;
            frame_end = 1'b0;
            idle_evt = 1'b0;
        end
    end

    // a mismatching address mark mutes; a matching one wakes and is kept
    always_comb begin
        rx_accept = 1'b0;
        mute_set = 1'b0;
        mute_clr = 1'b0;
        if (frame_end && ctrl_r.rx_mute) begin
            if (ctrl_r.wake_addr && addr_hit) begin
                mute_clr = 1'b1;
                rx_accept = 1'b1;
            end
        end else if (frame_end) begin
            if (ctrl_r.wake_addr && is_addr && !addr_hit) begin
                mute_set = 1'b1;
            end else begin
                rx_accept = 1'b1;
            end
        end
        if (idle_evt && ctrl_r.rx_mute && !ctrl_r.wake_addr) begin
            mute_clr = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rxm_r <= 1'b1;
            rxs_r <= 1'b1;
            rst_r <= SPM_IDLE;
            rcnt_r <= 16'h0000;
            rbit_r <= 4'h0;
            rsh_r <= 9'h000;
            icnt_r <= 4'h0;
            iarm_r <= 1'b0;
        end else begin
            rxm_r <= rxm_nxt;
            rxs_r <= rxs_nxt;
            rst_r <= rst_nxt;
            rcnt_r <= rcnt_nxt;
            rbit_r <= rbit_nxt;
            rsh_r <= rsh_nxt;
            icnt_r <= icnt_nxt;
            iarm_r <= iarm_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_unit_off_line: assert property (!ctrl_r.unit_on ##1 !ctrl_r.unit_on |-> txd_o)
        else $error("line not idle while unit is off");
    a_unit_off_abort: assert property (!ctrl_r.unit_on |=> rst_r == SPM_IDLE && !tx_done)
        else $error("frame kept running after unit off");
    a_tx_gate: assert property (tx_take |-> ctrl_r.tx_on && ctrl_r.unit_on)
        else $error("frame started with transmit off");
    a_rx_gate: assert property (!ctrl_r.rx_on |=> rst_r == SPM_IDLE && !rx_accept)
        else $error("receiver ran with receive off");
    a_rx_len8: assert property (rx_accept && !stat_r.rx_full_flag && !ctrl_r.word9
        |=> rdr_r[8] == 1'b0)
        else $error("eight bit frame stored a ninth bit");
    a_par_flag: assert property (rx_accept && !stat_r.rx_full_flag && perr
        |=> stat_r.parity_err_flag ##1 stat_r.parity_err_flag || stat_rd_r)
        else $error("parity mismatch not flagged");
    a_idle_wake: assert property (idle_evt && ctrl_r.rx_mute && !ctrl_r.wake_addr
        |=> !ctrl_r.rx_mute)
        else $error("idle line did not wake receiver");
    a_addr_wake: assert property (frame_end && ctrl_r.rx_mute && ctrl_r.wake_addr
        && addr_hit |=> !ctrl_r.rx_mute && stat_r.rx_full_flag)
        else $error("address mark did not wake receiver");
    a_mute_lock: assert property (wr_ctrl && ctrl_r.wake_addr && stat_r.rx_full_flag
        && !mute_set && !mute_clr |=> $stable(ctrl_r.rx_mute))
        else $error("mute changed by write while locked");
    a_irq_quiet: assert property (ctrl_r[8:4] == 5'h00 |=> !irq_o)
        else $error("interrupt with every enable low");
    a_irq_par: assert property (stat_r.parity_err_flag && ctrl_r.parity_err_irq_en
        |=> irq_o)
        else $error("parity interrupt missing");
    a_irq_ovr: assert property (stat_r.overrun_flag && ctrl_r.rx_full_irq_en
        |=> irq_o)
        else $error("overrun interrupt missing");

    c_frame_rx: cover property (rx_accept ##[1:40] rd_en);
    c_addr_wake: cover property (mute_clr && ctrl_r.wake_addr);
    c_tx_done: cover property (tx_done && !tdr_full_r);
    c_overrun: cover property (rx_accept && stat_r.rx_full_flag);
endmodule : spm_serial_ctrl

// File: spm_peer.sv
// spm_peer: remote serial node facing the transceiver
// assumes the bench sets bit time and data bits per frame
`timescale 1ns/1ps
module spm_peer (
    input wire logic clk_sys_i,
    input wire logic txd_i,
    input wire logic [15:0] div_i,
    input wire logic [3:0] nbits_i,
    output logic rxd_o,
    output logic [8:0] got_o,
    output logic [7:0] frames_o
);
    initial begin
        rxd_o = 1'b1;
        got_o = 9'h000;
        frames_o = 8'h00;
    end
    // frame given whole: start low, data lsb first, stop high
    task automatic send(input logic [10:0] f, input int nb);
        for (int i = 0; i < nb; i++) begin
            rxd_o <= f[i];
            repeat (div_i) @(posedge clk_sys_i);
        end
        rxd_o <= 1'b1;
    endtask : send
    // sample mid-bit so the design's output register skew does not matter
    always begin
        @(negedge txd_i);
        got_o <= 9'h000;
        repeat (div_i / 2 + div_i) @(posedge clk_sys_i);
        for (int i = 0; i < nbits_i; i++) begin
            got_o[i] <= txd_i;
            repeat (div_i) @(posedge clk_sys_i);
        end
        frames_o <= frames_o + 8'h01;
    end
endmodule : spm_peer

// File: spm_serial_ctrl_tb.sv
// spm_serial_ctrl_tb: register and line tests of the transceiver
// assumes a 125 MHz clock and the peer model on the serial line
`timescale 1ns/1ps
module spm_serial_ctrl_tb import spm_pkg::*;;
    `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] q;
    logic [31:0] rdata;
    logic wq, rxd, txd, irq;
    logic [15:0] div = 16'h0004;
    logic [3:0] nb = 4'h8;
    logic [8:0] got;
    logic [7:0] frames;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    spm_serial_ctrl DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(q),
        .avs_waitrequest_o(wq), .rxd_i(rxd), .txd_o(txd), .irq_o(irq));
    spm_peer peer (.clk_sys_i(clk_sys_i), .txd_i(txd), .div_i(div), .nbits_i(nb),
        .rxd_o(rxd), .got_o(got), .frames_o(frames));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    // request held until waitrequest is seen low at a rising edge; the cycle timeout ends a hang
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_sys_i);
        end while (wq !== 1'b0);
        rdata = q;
        rd <= 1'b0;
        wr <= 1'b0;
        // two idle edges so registered flags and irq have settled before any check
        repeat (2) @(posedge clk_sys_i);
    endtask : bus
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rdata, e)
    endtask : rdc
    task automatic txf(input logic [8:0] d, input logic [8:0] e);
        logic [7:0] f0;
        f0 = frames;
        bus(1'b1, SPM_OFS_DATA, {23'h000000, d});
        while (frames === f0) begin
            @(posedge clk_sys_i);
        end
        repeat (12) @(posedge clk_sys_i);
        `CHK(got, e)
    endtask : txf
    task automatic rxf(input logic [7:0] d);
        peer.send({1'b1, d, 1'b0}, 10);
        repeat (20) @(posedge clk_sys_i);
    endtask : rxf
    initial begin
        logic [7:0] fs;
        logic ok;
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        rdc(SPM_OFS_CTRL, SPM_CTRL_RST);
        rdc(SPM_OFS_STAT, SPM_STAT_RST);
        rdc(5'h1C, 32'h0000_0000);
        bus(1'b1, SPM_OFS_DIV, {16'h0000, div});
        bus(1'b1, SPM_OFS_CTRL, 32'hFFFF_FFFF);
        rdc(SPM_OFS_CTRL, 32'h0000_3FFE);
        `CHK(irq, 1'b1)
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2000);
        `CHK(irq, 1'b0)
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2080);
        `CHK(irq, 1'b1)
        $display("test registers done");
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2048);
        txf(9'h0A5, 9'h0A5);
        `CHK(irq, 1'b1)
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2608);
        txf(9'h0FF, 9'h07F);
        nb <= 4'h9;
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_3608);
        txf(9'h1FE, 9'h0FE);
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_3408);
        txf(9'h0FE, 9'h1FE);
        nb <= 4'h8;
        $display("test transmit done");
        rdc(SPM_OFS_STAT, 32'h0000_00C0);
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_0000);
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2000);
        fs = frames;
        bus(1'b1, SPM_OFS_DATA, 32'h0000_0055);
        repeat (80) @(posedge clk_sys_i);
        `CHK(frames, fs)
        // tx_on kept high so only the unit_on drop can stop the frame
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2008);
        bus(1'b1, SPM_OFS_DATA, 32'h0000_0000);
        repeat (12) @(posedge clk_sys_i);
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_0008);
        `CHK(txd, 1'b1)
        ok = 1'b1;
        repeat (60) begin
            @(posedge clk_sys_i);
            ok &= txd;
        end
        `CHK(ok, 1'b1)
        $display("test abort done");
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2024);
        rxf(8'h3C);
        `CHK(irq, 1'b1)
        rdc(SPM_OFS_DATA, 32'h0000_003C);
        `CHK(irq, 1'b0)
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2020);
        rxf(8'h3C);
        `CHK(irq, 1'b0)
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2504);
        rxf(8'h01);
        `CHK(irq, 1'b1)
        bus(1'b0, SPM_OFS_STAT, 32'h0000_0000);
        `CHK(rdata[0], 1'b1)
        bus(1'b0, SPM_OFS_DATA, 32'h0000_0000);
        `CHK(rdata, 32'h0000_0001)
        `CHK(irq, 1'b0)
        $display("test receive done");
        // the received byte has been read out, so mute may be entered
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2806);
        rdc(SPM_OFS_CTRL, 32'h0000_2806);
        rxf(8'h80);
        rdc(SPM_OFS_CTRL, 32'h0000_2804);
        bus(1'b1, SPM_OFS_CTRL, 32'h0000_2806);
        rdc(SPM_OFS_CTRL, 32'h0000_2804);
        $display("test mute done");
        results();
    end
endmodule : spm_serial_ctrl_tb
